// [src/iscp_top.sv]
// interrupt combine logic, reference slew status and status pin drivers behind an AHB-Lite slave
// assumes one clock, synchronous inputs, zero-wait single word transfers
//
// Overview of operation
// R1: combine unmasked flags with AND when select bit is 1, OR when 0.
// R2: edge of configured polarity sets a sticky flag; writing zero clears it.
// R3: interrupt enable 1 runs the interrupt circuit; 0 disables it.
// R4: with enable 0 no interrupt appears on either status pin.
// R5: with enable 0 the sticky flags never change from source edges.
// R6: live register always shows the present interrupt sources.
// R7: bits 7 and 6 of slew status show alternate reference rise/fall valid.
// R8: bits 5 and 4 of slew status show main reference rise/fall valid.
// R9: open-drain bit 1 or 0 makes pin one or zero open-drain.
// R10: limit bit 5 or 4 puts pin one or zero into spike-limited mode.
// R11: when enabled, the routed status pin shows the combined interrupt.
//
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ns
`include "iscp_defs.svh"

module iscp_top (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  // register bus
  input wire iscp_pkg::iscp_ahb_req_t ahb_req,
  output iscp_pkg::iscp_ahb_rsp_t ahb_rsp,
  // device sources
  input wire logic [7:0] irq_src,
  input wire iscp_pkg::iscp_slew_t slew,
  input wire logic [1:0] pin_src,
  // status pins
  output iscp_pkg::iscp_pins_t pins
);

  iscp_pkg::iscp_state_t state_ff, nxt_state;
  logic [7:0] widx_ff, nxt_widx;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic [1:0] interrupt_control_ff, nxt_interrupt_control;
  logic [5:0] status_pin_driver_control_ff, nxt_status_pin_driver_control;
  logic [7:0] mask_ff, nxt_mask;
  logic [7:0] pol_ff, nxt_pol;
  logic [7:0] flags_ff, nxt_flags;
  logic [7:0] prev_ff, nxt_prev;
  logic route_ff, nxt_route;
  logic irq_ff, nxt_irq;
  logic [1:0] pin_o_ff, nxt_pin_o;
  logic [1:0] pin_oe_ff, nxt_pin_oe;

  logic addr_ok, take;
  logic [7:0] aidx;
  logic wr_en;
  logic [7:0] ev, set_vec, unm;
  logic and_hit, or_hit;
  logic [1:0] lvl;

  assign aidx = ahb_req.haddr[9:2];
  assign addr_ok = (ahb_req.haddr[31:10] == 22'h00_0000);
  assign take = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == `ISCP_HTRANS_NONSEQ);
  assign wr_en = (state_ff == iscp_pkg::ISCP_WR);

  assign ahb_rsp.hrdata = hrdata_ff;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp = 1'b0;

  // bus phases; read data is sampled at address phase so it stands for the data phase
  always_comb begin
    nxt_state = iscp_pkg::ISCP_IDLE;
    nxt_widx = widx_ff;
    nxt_hrdata = hrdata_ff;
    if (take) begin
      nxt_widx = addr_ok ? aidx : 8'hFF;
      if (ahb_req.hwrite) begin
        nxt_state = iscp_pkg::ISCP_WR;
      end else begin
        nxt_state = iscp_pkg::ISCP_RD;
        nxt_hrdata = 32'h0000_0000;
        if (addr_ok) begin
          case (aidx)
            `ISCP_IDX_INTERRUPT_CONTROL: nxt_hrdata[1:0] = interrupt_control_ff;
            `ISCP_IDX_SLEW: nxt_hrdata[7:4] = slew; // [R7] [R8]
            `ISCP_IDX_STATUS_PIN_DRIVER_CONTROL: nxt_hrdata[5:0] = status_pin_driver_control_ff;
            `ISCP_IDX_MASK: nxt_hrdata[7:0] = mask_ff;
            `ISCP_IDX_LIVE: nxt_hrdata[7:0] = irq_src; // [R6]
            `ISCP_IDX_POL: nxt_hrdata[7:0] = pol_ff;
            `ISCP_IDX_FLAGS: nxt_hrdata[7:0] = flags_ff;
            `ISCP_IDX_ROUTE: nxt_hrdata[0] = route_ff;
            default: nxt_hrdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_ff <= iscp_pkg::ISCP_IDLE;
      widx_ff <= `ISCP_RST_BYTE;
      hrdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      state_ff <= nxt_state;
      widx_ff <= nxt_widx;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // configuration registers written in the data phase
  always_comb begin
    nxt_interrupt_control = interrupt_control_ff;
    nxt_status_pin_driver_control = status_pin_driver_control_ff;
    nxt_mask = mask_ff;
    nxt_pol = pol_ff;
    nxt_route = route_ff;
    if (wr_en) begin
      case (widx_ff)
        `ISCP_IDX_INTERRUPT_CONTROL: nxt_interrupt_control = ahb_req.hwdata[1:0];
        `ISCP_IDX_STATUS_PIN_DRIVER_CONTROL: nxt_status_pin_driver_control = ahb_req.hwdata[5:0];
        `ISCP_IDX_MASK: nxt_mask = ahb_req.hwdata[7:0];
        `ISCP_IDX_POL: nxt_pol = ahb_req.hwdata[7:0];
        `ISCP_IDX_ROUTE: nxt_route = ahb_req.hwdata[0];
        default: nxt_route = route_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      interrupt_control_ff <= `ISCP_RST_INTERRUPT_CONTROL;
      status_pin_driver_control_ff <= `ISCP_RST_STATUS_PIN_DRIVER_CONTROL;
      mask_ff <= `ISCP_RST_BYTE;
      pol_ff <= `ISCP_RST_BYTE;
      route_ff <= 1'b0;
    end else if (ce) begin
      interrupt_control_ff <= nxt_interrupt_control;
      status_pin_driver_control_ff <= nxt_status_pin_driver_control;
      mask_ff <= nxt_mask;
      pol_ff <= nxt_pol;
      route_ff <= nxt_route;
    end
  end

  // sticky flags: a set in the same cycle as a clearing write wins
  always_comb begin
    ev = (pol_ff & irq_src & ~prev_ff) | (~pol_ff & ~irq_src & prev_ff);
    set_vec = interrupt_control_ff[`ISCP_BIT_INT_EN] ? ev : 8'h00; // [R2] [R3] [R5]
    nxt_prev = irq_src;
    nxt_flags = flags_ff;
    if (wr_en && widx_ff == `ISCP_IDX_FLAGS) begin
      nxt_flags = flags_ff & ahb_req.hwdata[7:0]; // [R2]
    end
    nxt_flags = nxt_flags | set_vec;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_ff <= `ISCP_RST_BYTE;
      prev_ff <= `ISCP_RST_BYTE;
    end else if (ce) begin
      flags_ff <= nxt_flags;
      prev_ff <= nxt_prev;
    end
  end

  // combine and pin drive; an empty mask never fires in AND mode
  always_comb begin
    unm = flags_ff & mask_ff;
    and_hit = (mask_ff != 8'h00) && (unm == mask_ff);
    or_hit = (unm != 8'h00);
    nxt_irq = interrupt_control_ff[`ISCP_BIT_INT_EN] && // [R3] [R4]
              (interrupt_control_ff[`ISCP_BIT_AND_OR] ? and_hit : or_hit); // [R1]
    lvl = pin_src;
    lvl[route_ff] = irq_ff; // [R11]
    nxt_pin_o = lvl;
    nxt_pin_oe = 2'b11;
    if (status_pin_driver_control_ff[`ISCP_BIT_OD0]) begin
      nxt_pin_o[0] = 1'b0; // [R9]
      nxt_pin_oe[0] = ~lvl[0];
    end
    if (status_pin_driver_control_ff[`ISCP_BIT_OD1]) begin
      nxt_pin_o[1] = 1'b0; // [R9]
      nxt_pin_oe[1] = ~lvl[1];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
      pin_o_ff <= 2'b00;
      pin_oe_ff <= 2'b00;
    end else if (ce) begin
      irq_ff <= nxt_irq;
      pin_o_ff <= nxt_pin_o;
      pin_oe_ff <= nxt_pin_oe;
    end
  end

  assign pins.o = pin_o_ff;
  assign pins.oe = pin_oe_ff;
  // the pad trades edge rate for lower shoot-through current
  assign pins.spike_limit = {status_pin_driver_control_ff[`ISCP_BIT_LIM1], status_pin_driver_control_ff[`ISCP_BIT_LIM0]}; // [R10]

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_off_twice;
    ce && !interrupt_control_ff[0] ##1 ce && !interrupt_control_ff[0];
  endsequence

  sequence s_flag_clear;
    ce && wr_en && widx_ff == `ISCP_IDX_FLAGS && set_vec == 8'h00;
  endsequence

  chk_and_mode: assert property (ce && interrupt_control_ff == 2'b11 && and_hit |=> irq_ff) // [R1]
    else $error("and combine missed");
  chk_or_mode: assert property (ce && interrupt_control_ff == 2'b01 && or_hit |=> irq_ff) // [R1]
    else $error("or combine missed");
  chk_and_partial: assert property (ce && interrupt_control_ff[1] && !and_hit |=> !irq_ff) // [R1]
    else $error("and combine fired on partial set");
  chk_flag_set: assert property (ce && set_vec != 8'h00 |=> (flags_ff & $past(set_vec)) == $past(set_vec)) // [R2]
    else $error("edge did not set flag");
  chk_flag_clear: assert property (s_flag_clear |=> flags_ff == ($past(flags_ff) & $past(ahb_req.hwdata[7:0]))) // [R2]
    else $error("write zero did not clear flag");
  chk_off_no_irq: assert property (s_off_twice |=> !irq_ff) // [R3] [R4]
    else $error("interrupt while disabled");
  chk_off_frozen: assert property (ce && !interrupt_control_ff[0] && !(wr_en && widx_ff == `ISCP_IDX_FLAGS) |=> $stable(flags_ff)) // [R5]
    else $error("flags changed while disabled");
  chk_live_read: assert property (ce && take && !ahb_req.hwrite && addr_ok && aidx == `ISCP_IDX_LIVE // [R6]
                                  |=> hrdata_ff[7:0] == $past(irq_src))
    else $error("live read mismatch");
  chk_slew_read: assert property (ce && take && !ahb_req.hwrite && addr_ok && aidx == `ISCP_IDX_SLEW // [R7] [R8]
                                  |=> hrdata_ff[7:4] == $past(slew) && hrdata_ff[3:0] == 4'h0)
    else $error("slew status read mismatch");
  chk_open_drain: assert property (ce && status_pin_driver_control_ff[0] && !lvl[0] |=> pin_oe_ff[0] && !pin_o_ff[0]) // [R9]
    else $error("open drain pin zero not pulling low");
  chk_od_release: assert property (ce && status_pin_driver_control_ff[1] && lvl[1] |=> !pin_oe_ff[1]) // [R9]
    else $error("open drain pin one not released");
  chk_limit_write: assert property (ce && wr_en && widx_ff == `ISCP_IDX_STATUS_PIN_DRIVER_CONTROL // [R10]
                                    |=> pins.spike_limit == $past(ahb_req.hwdata[5:4]))
    else $error("spike limit not applied");
  chk_pin_route: assert property (ce && !route_ff && !status_pin_driver_control_ff[0] |=> pin_o_ff[0] == $past(irq_ff)) // [R11]
    else $error("routed pin does not follow interrupt");

  // pin-path checks built from steps: a qualifying cycle, then the pin cycle
  sequence s_off_once;
    ce && !interrupt_control_ff[`ISCP_BIT_INT_EN];
  endsequence

  sequence s_or_fire;
    ce && interrupt_control_ff == 2'b01 && or_hit;
  endsequence

  sequence s_pin0_pp;
    ce && !route_ff && !status_pin_driver_control_ff[`ISCP_BIT_OD0];
  endsequence

  sequence s_pin0_od;
    ce && !route_ff && status_pin_driver_control_ff[`ISCP_BIT_OD0];
  endsequence

  chk_off_pin_zero: assert property (s_off_once ##1 s_pin0_pp |=> !pin_o_ff[0]) // [R4]
    else $error("disabled interrupt reached push-pull pin zero");
  chk_off_od_zero: assert property (s_off_once ##1 s_pin0_od |=> pin_oe_ff[0] && !pin_o_ff[0]) // [R4]
    else $error("disabled interrupt released open drain pin zero");
  chk_or_to_pin: assert property (s_or_fire ##1 s_pin0_pp |=> pin_o_ff[0]) // [R11] [R1]
    else $error("or combine did not reach pin zero");
  chk_or_idle: assert property (ce && !interrupt_control_ff[`ISCP_BIT_AND_OR] && !or_hit |=> !irq_ff) // [R1]
    else $error("or combine fired with no unmasked flag");

  // sticky flags move only by an edge or a clearing write
  chk_flag_sticky: assert property (ce && !(wr_en && widx_ff == `ISCP_IDX_FLAGS) // [R2]
                                    |=> (flags_ff & $past(flags_ff)) == $past(flags_ff))
    else $error("flag dropped without a clearing write");
  chk_no_spurious: assert property (ce && set_vec == 8'h00 // [R2] [R5]
                                    |=> (flags_ff & ~$past(flags_ff)) == 8'h00)
    else $error("flag set without a qualifying edge");
  chk_pol_write: assert property (ce && wr_en && widx_ff == `ISCP_IDX_POL // [R2]
                                  |=> pol_ff == $past(ahb_req.hwdata[7:0]))
    else $error("polarity write lost");

  // pin drivers and the pin that is not carrying the interrupt
  chk_pp_drive: assert property (ce && !status_pin_driver_control_ff[`ISCP_BIT_OD0] // [R9]
                                 |=> pin_oe_ff[0] && pin_o_ff[0] == $past(lvl[0]))
    else $error("push-pull pin zero not driving its level");
  chk_od_one_low: assert property (ce && status_pin_driver_control_ff[`ISCP_BIT_OD1] && !lvl[1] // [R9]
                                   |=> pin_oe_ff[1] && !pin_o_ff[1])
    else $error("open drain pin one not pulling low");
  chk_route_one: assert property (ce && route_ff && !status_pin_driver_control_ff[`ISCP_BIT_OD1] // [R11]
                                  |=> pin_o_ff[1] == $past(irq_ff))
    else $error("pin one does not follow interrupt when routed");
  chk_pin_one_plain: assert property (ce && !route_ff && !status_pin_driver_control_ff[`ISCP_BIT_OD1] // [R11]
                                      |=> pin_o_ff[1] == $past(pin_src[1]))
    else $error("unrouted pin one does not follow its source");

  // control writes land at the end of the data phase
  chk_interrupt_control_write: assert property (ce && wr_en && widx_ff == `ISCP_IDX_INTERRUPT_CONTROL // [R3]
                                     |=> interrupt_control_ff == $past(ahb_req.hwdata[1:0]))
    else $error("interrupt control write lost");
  chk_status_pin_driver_control_write: assert property (ce && wr_en && widx_ff == `ISCP_IDX_STATUS_PIN_DRIVER_CONTROL // [R9]
                                      |=> status_pin_driver_control_ff[1:0] == $past(ahb_req.hwdata[1:0]))
    else $error("open drain select write lost");
  chk_route_write: assert property (ce && wr_en && widx_ff == `ISCP_IDX_ROUTE // [R11]
                                    |=> route_ff == $past(ahb_req.hwdata[0]))
    else $error("route write lost");
  chk_limit_stable: assert property (ce && !(wr_en && widx_ff == `ISCP_IDX_STATUS_PIN_DRIVER_CONTROL) // [R10]
                                     |=> $stable(pins.spike_limit))
    else $error("spike limit moved without a write");

endmodule

// [src/iscp_defs.svh]
// register indices, field positions and reset values of the status pin and interrupt block
// assumes register index = word address (byte address = 4 * index)
`ifndef ISCP_DEFS_SVH
`define ISCP_DEFS_SVH
`define ISCP_IDX_INTERRUPT_CONTROL 8'h11
`define ISCP_IDX_SLEW 8'h12
`define ISCP_IDX_STATUS_PIN_DRIVER_CONTROL 8'h13
`define ISCP_IDX_MASK 8'h20
`define ISCP_IDX_LIVE 8'h21
`define ISCP_IDX_POL 8'h22
`define ISCP_IDX_FLAGS 8'h23
`define ISCP_IDX_ROUTE 8'h24
`define ISCP_BIT_INT_EN 0
`define ISCP_BIT_AND_OR 1
`define ISCP_BIT_OD0 0
`define ISCP_BIT_OD1 1
`define ISCP_BIT_LIM0 4
`define ISCP_BIT_LIM1 5
`define ISCP_SLEW_LSB 4
`define ISCP_RST_INTERRUPT_CONTROL 2'h0
`define ISCP_RST_STATUS_PIN_DRIVER_CONTROL 6'h00
`define ISCP_RST_BYTE 8'h00
`define ISCP_HTRANS_NONSEQ 2'h2
`endif

// [src/iscp_pkg.sv]
// types shared by the status pin and interrupt block
// assumes AHB-Lite signal names as published
package iscp_pkg;
  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } iscp_ahb_req_t;
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } iscp_ahb_rsp_t;
  typedef struct packed {
    logic alt_ref_rise_ok;
    logic alt_ref_fall_ok;
    logic main_ref_rise_ok;
    logic main_ref_fall_ok;
  } iscp_slew_t;
  typedef struct packed {
    logic [1:0] o;
    logic [1:0] oe;
    logic [1:0] spike_limit;
  } iscp_pins_t;
  typedef enum logic [2:0] {
    ISCP_IDLE = 3'b001,
    ISCP_WR = 3'b010,
    ISCP_RD = 3'b100
  } iscp_state_t;
endpackage

// [dv/iscp_host_mon.sv]
// board-side model that watches the two status pins
// assumes a pull-up on each pin, as an open-drain line needs
`timescale 1ns/1ns
module iscp_host_mon (
  // pin drivers of the device
  input wire iscp_pkg::iscp_pins_t pins,
  // resolved pin levels
  output logic [1:0] lvl
);
  // a released pin floats up to the pull-up level
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      lvl[k] = pins.oe[k] ? pins.o[k] : 1'b1;
    end
  end
endmodule

// [dv/tb.sv]
// self-checking bench for the status pin and interrupt block
// assumes zero-wait AHB-Lite slave and pin zero routed to the interrupt, save one step that routes it to pin one
`timescale 1ns/1ns
module tb;
  logic ref_clk;
  logic rst;
  logic ce;
  iscp_pkg::iscp_ahb_req_t rq;
  iscp_pkg::iscp_ahb_req_t ahb_req;
  iscp_pkg::iscp_ahb_rsp_t ahb_rsp;
  iscp_pkg::iscp_slew_t slew;
  iscp_pkg::iscp_pins_t pins;
  logic [7:0] irq_src;
  logic [7:0] seed;
  logic [7:0] w;
  logic [1:0] pin_src;
  logic [1:0] lvl;
  logic [1:0] lv;
  logic [31:0] rd;
  iscp_pkg::iscp_pins_t pin_snap;
  logic [1:0] lvl_snap;
  int err_count;
  int checked;
  int cyc;
  iscp_top DUT (.ref_clk(ref_clk), .rst(rst), .ce(ce), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
    .irq_src(irq_src), .slew(slew), .pin_src(pin_src), .pins(pins));
  iscp_host_mon host (.pins(pins), .lvl(lvl));
  always #5 ref_clk = ~ref_clk;
  // the lone slave's hreadyout is the bus's hready
  always_comb begin
    ahb_req = rq;
    ahb_req.hready = ahb_rsp.hreadyout;
  end
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // an open-drain pin drives only to pull low; push-pull always drives
  function automatic logic [1:0] exp_oe(logic [1:0] od, logic [1:0] level);
    return ~(od & level);
  endfunction
  task print_verdict;
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one single-word transfer; no wait count assumed, only hready ends a phase
  task automatic bus(logic wr, logic [7:0] idx, logic [31:0] wd);
    rq.hsel <= 1'b1;
    rq.htrans <= 2'h2;
    rq.haddr <= {22'h0, idx, 2'h0};
    rq.hwrite <= wr;
    rq.hsize <= 3'h2;
    do @(posedge ref_clk); while (ahb_rsp.hreadyout !== 1'b1);
    rq.htrans <= 2'h0;
    rq.hwdata <= wd;
    do @(posedge ref_clk); while (ahb_rsp.hreadyout !== 1'b1);
    rd = ahb_rsp.hrdata;
  endtask
  // pin path is three edges deep; snapshot once it has landed, return on an edge so drives stay aligned
  task automatic settle(int n);
    repeat (n) @(posedge ref_clk);
    #1;
    pin_snap = pins;
    lvl_snap = lvl;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    rq = '0;
    irq_src = 8'h00;
    slew = 4'h0;
    pin_src = 2'h0;
    seed = 8'h51;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, 8'h11, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h30, 32'hFFFF_FFFF);
    bus(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, 8'h20, 32'hFF);
    bus(1'b1, 8'h22, 32'hFF);
    // random source edges while disabled must leave flags and pin zero quiet; pin one follows pin_src[1]
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      w = seed & 8'h33;
      irq_src <= seed;
      slew <= seed[3:0];
      pin_src <= seed[7:6];
      bus(1'b1, 8'h13, {24'h0, w});
      bus(1'b0, 8'h12, 32'h0);
      chk(rd, {24'h0, seed[3:0], 4'h0});
      bus(1'b0, 8'h21, 32'h0);
      chk(rd, {24'h0, seed});
      bus(1'b0, 8'h23, 32'h0);
      chk(rd, 32'h0);
      bus(1'b0, 8'h13, 32'h0);
      chk(rd, {24'h0, w});
      settle(3);
      lv = {pin_src[1], 1'b0};
      chk(pin_snap.spike_limit, w[5:4]);
      chk(pin_snap.oe, exp_oe(w[1:0], lv));
      chk(lvl_snap, lv);
    end
    bus(1'b1, 8'h13, 32'h0);
    irq_src <= 8'h00;
    bus(1'b1, 8'h23, 32'h0);
    bus(1'b1, 8'h11, 32'h1);
    irq_src <= 8'h08;
    settle(3);
    chk(pin_snap.o[0], 1'b1);
    // moving the interrupt to pin one hands pin zero back to its plain source
    bus(1'b1, 8'h24, 32'h1);
    settle(2);
    chk(pin_snap.o, {1'b1, pin_src[0]});
    bus(1'b1, 8'h24, 32'h0);
    bus(1'b0, 8'h23, 32'h0);
    chk(rd, 32'h08);
    bus(1'b1, 8'h23, 32'h0);
    settle(3);
    chk(pin_snap.o[0], 1'b0);
    // all unmasked flags needed in the and mode
    bus(1'b1, 8'h20, 32'h03);
    bus(1'b1, 8'h11, 32'h3);
    irq_src <= 8'h09;
    settle(3);
    chk(pin_snap.o[0], 1'b0);
    irq_src <= 8'h0B;
    settle(3);
    chk(pin_snap.o[0], 1'b1);
    bus(1'b1, 8'h11, 32'h2);
    settle(3);
    chk(pin_snap.o[0], 1'b0);
    print_verdict();
  end
endmodule
